// File: rtl/serdes_ctrl_params.svh
// Offsets, field positions, reset values and code points of the global control register bank
`ifndef SERDES_CTRL_PARAMS_SVH
`define SERDES_CTRL_PARAMS_SVH

`define REG_RESERVED_CTRL_A 5'h17
`define REG_GLOBAL_MODE_CONTROL 5'h18
`define REG_RESERVED_CTRL_B 5'h19
`define REG_RESERVED_STAT_0 5'h1a
`define REG_RESERVED_STAT_1 5'h1b
`define REG_RESERVED_STAT_2 5'h1c

`define GMC_RESET 16'h100c
`define GMC_WRITE_MASK 16'hd30c
`define GMC_GIG_ETH_BIT 15
`define GMC_BUSY_BIT 14
`define GMC_CTC_BIT 12
`define GMC_CHECK_BIT 9
`define GMC_GEN_BIT 8
`define GMC_EMPH_HI 3
`define GMC_EMPH_LO 2

`define MDIO_PREAMBLE_LEN 6'h20
`define MDIO_OP_READ 2'h2
`define MDIO_OP_WRITE 2'h1
`define MDIO_LAST_OP_BIT 4'h1
`define MDIO_LAST_ADDR_BIT 4'h9
`define MDIO_LAST_DATA_BIT 4'hf

`define CODE_K28_5 8'hbc
`define CODE_D10_1 8'h2a
`define CODE_D15_2 8'h4f
`define CODE_D5_6 8'hc5

`endif

// File: rtl/serdes_ctrl_pkg.sv
// Types shared by the global control register bank
package serdes_ctrl_pkg;
    typedef enum logic [2:0] {
        MG_PREAMBLE = 3'h0,
        MG_START = 3'h1,
        MG_OPCODE = 3'h3,
        MG_ADDRESS = 3'h2,
        MG_TURN = 3'h6,
        MG_DATA = 3'h7
    } mgmt_state_t;
endpackage

// File: rtl/global_serdes_control_regs.sv
// Global mode control register bank with management frame slave and idle handling
//
// Contract
// - In gig-eth mode, K28.5 followed by any data character is an idle sequence.
// - With busy active, K28.5 D10.1 follows busy handling, not idle handling.
// - In gig-eth mode transmit D5.6 instead of D15.2 after K28.5.
// - Effective gig-eth mode is register bit OR gig-eth select pin.
// - Busy set: K28.5 D10.1 passes through as ordinary data.
// - Busy clear: K28.5 D10.1 is treated as idle.
// - Effective busy mode is register bit OR busy pin.
// - Busy behaviour only acts while gig-eth mode is effective.
// - Pattern check bit enables checking on all receive channels.
// - Pattern generate bit enables generation on all channels.
// - Two-bit emphasis field selects none, low, mid, high; resets to high.
// - Bit 13 of the control register reads zero, writes ignored.
// - Bits 11:10 and 7:4 read zero, writes ignored.
// - Registers 0x17 and 0x19 to 0x1c read zero and are read-only.
`timescale 1ns/100ps
`default_nettype none
`include "serdes_ctrl_params.svh"

module global_serdes_control_regs
    import serdes_ctrl_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [4:0] phy_address,
    input wire logic mdc,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe_n,
    input wire logic gig_eth_select_pin,
    input wire logic busy_passthrough_pin,
    input wire logic rx_code_valid,
    input wire logic [7:0] rx_code,
    input wire logic rx_is_control,
    output logic rx_idle_seq,
    output logic rx_busy_data,
    input wire logic tx_code_valid,
    input wire logic [7:0] tx_code,
    input wire logic tx_is_control,
    output logic tx_code_out_valid,
    output logic [7:0] tx_code_out,
    output logic tx_is_control_out,
    output logic gig_eth_idle_handling,
    output logic busy_sequence_passthrough,
    output logic clock_tolerance_comp_on,
    output logic pattern_check_global_on,
    output logic pattern_gen_global_on,
    output logic [1:0] global_tx_emphasis_level
);

    logic [15:0] global_mode_control;
    logic mdc_q;
    logic mdc_rise;
    mgmt_state_t mg_state;
    logic [5:0] ones_count;
    logic [3:0] bit_count;
    logic [1:0] op_code;
    logic [9:0] addr_shift;
    logic [15:0] data_shift;
    logic reading;
    logic rx_prev_comma;
    logic tx_prev_comma;
    logic ge_eff;
    logic busy_eff;
    logic frame_step;
    logic op_done;
    logic addr_done;
    logic data_done;
    logic write_hit;

    // Read value of a register index; everything except the mode register reads zero
    function automatic logic [15:0] read_value(input logic [4:0] idx, input logic [15:0] ctrl);
        logic [15:0] v;
        v = 16'h0000;
        if (idx == `REG_GLOBAL_MODE_CONTROL) begin
            v = ctrl & `GMC_WRITE_MASK;
        end
        return v;
    endfunction

    // Comma character of an idle pair, shared by the receive and transmit paths
    function automatic logic is_comma(input logic is_control, input logic [7:0] code);
        return is_control && (code == `CODE_K28_5);
    endfunction

    // End test of the bit counter, shared by the opcode, address and data fields of the frame
    function automatic logic field_done(input logic [3:0] count, input logic [3:0] last);
        return count == last;
    endfunction

    assign mdc_rise = mdc & ~mdc_q;
    assign frame_step = clk_en & mdc_rise;
    assign op_done = field_done(bit_count, `MDIO_LAST_OP_BIT);
    assign addr_done = field_done(bit_count, `MDIO_LAST_ADDR_BIT);
    assign data_done = field_done(bit_count, `MDIO_LAST_DATA_BIT);
    // Last data bit of a write frame to this port and the mode register
    assign write_hit = (mg_state == MG_DATA) && data_done && (op_code == `MDIO_OP_WRITE) &&
                       (addr_shift[9:5] == phy_address) && (addr_shift[4:0] == `REG_GLOBAL_MODE_CONTROL);
    assign ge_eff = global_mode_control[`GMC_GIG_ETH_BIT] | gig_eth_select_pin;
    assign busy_eff = global_mode_control[`GMC_BUSY_BIT] | busy_passthrough_pin;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            mdc_q <= 1'b0;
        end else if (clk_en) begin
            mdc_q <= mdc;
        end
    end

    // Preamble ones, saturating at the minimum run length
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ones_count <= 6'h00;
        end else if (frame_step) begin
            if (mg_state != MG_PREAMBLE || !mdio_in) begin
                ones_count <= 6'h00;
            end else if (ones_count != `MDIO_PREAMBLE_LEN) begin
                ones_count <= ones_count + 6'h01;
            end
        end
    end

    // Frame state, one step per management clock rise
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            mg_state <= MG_PREAMBLE;
        end else if (frame_step) begin
            case (mg_state)
                MG_PREAMBLE: begin
                    if (!mdio_in && ones_count == `MDIO_PREAMBLE_LEN) begin
                        mg_state <= MG_START;
                    end
                end
                MG_START: begin
                    mg_state <= mdio_in ? MG_OPCODE : MG_PREAMBLE;
                end
                MG_OPCODE: begin
                    if (op_done) begin
                        mg_state <= MG_ADDRESS;
                    end
                end
                MG_ADDRESS: begin
                    if (addr_done) begin
                        mg_state <= MG_TURN;
                    end
                end
                MG_TURN: begin
                    if (bit_count != 4'h0) begin
                        mg_state <= MG_DATA;
                    end
                end
                MG_DATA: begin
                    if (data_done) begin
                        mg_state <= MG_PREAMBLE;
                    end
                end
                default: begin
                    mg_state <= MG_PREAMBLE;
                end
            endcase
        end
    end

    // Bit position inside the current field
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            bit_count <= 4'h0;
        end else if (frame_step) begin
            case (mg_state)
                MG_OPCODE: begin
                    bit_count <= op_done ? 4'h0 : bit_count + 4'h1;
                end
                MG_ADDRESS: begin
                    bit_count <= addr_done ? 4'h0 : bit_count + 4'h1;
                end
                MG_TURN: begin
                    bit_count <= (bit_count == 4'h0) ? 4'h1 : 4'h0;
                end
                MG_DATA: begin
                    bit_count <= data_done ? 4'h0 : bit_count + 4'h1;
                end
                default: begin
                    bit_count <= 4'h0;
                end
            endcase
        end
    end

    // Operation code and address fields, most significant bit first
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            op_code <= 2'h0;
            addr_shift <= 10'h000;
        end else if (frame_step) begin
            if (mg_state == MG_OPCODE) begin
                op_code <= {op_code[0], mdio_in};
            end
            if (mg_state == MG_ADDRESS) begin
                addr_shift <= {addr_shift[8:0], mdio_in};
            end
        end
    end

    // Read frame to this port; the last address bit is still in flight, so the port sits one place lower
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            reading <= 1'b0;
        end else if (frame_step) begin
            if (mg_state == MG_ADDRESS && addr_done) begin
                reading <= (op_code == `MDIO_OP_READ) && (addr_shift[8:4] == phy_address);
            end else if ((mg_state == MG_DATA && data_done) || mg_state == MG_PREAMBLE) begin
                reading <= 1'b0;
            end
        end
    end

    // Data shifter: loads the read value at turnaround, shifts out on reads and in on writes
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            data_shift <= 16'h0000;
        end else if (frame_step) begin
            case (mg_state)
                MG_TURN: begin
                    if (reading && bit_count == 4'h0) begin
                        data_shift <= read_value(addr_shift[4:0], global_mode_control);
                    end else if (reading) begin
                        data_shift <= {data_shift[14:0], 1'b0};
                    end
                end
                MG_DATA: begin
                    data_shift <= {data_shift[14:0], reading ? 1'b0 : mdio_in};
                end
                default: begin
                    data_shift <= data_shift;
                end
            endcase
        end
    end

    // Wire driver: zero in the second turnaround bit, then the read value, released otherwise
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            mdio_out <= 1'b1;
            mdio_oe_n <= 1'b1;
        end else if (frame_step) begin
            case (mg_state)
                MG_TURN: begin
                    if (reading) begin
                        mdio_oe_n <= 1'b0;
                        mdio_out <= (bit_count == 4'h0) ? 1'b0 : data_shift[15];
                    end
                end
                MG_DATA: begin
                    if (data_done) begin
                        mdio_oe_n <= 1'b1;
                        mdio_out <= 1'b1;
                    end else if (reading) begin
                        mdio_out <= data_shift[15];
                    end
                end
                default: begin
                    mdio_oe_n <= 1'b1;
                    mdio_out <= 1'b1;
                end
            endcase
        end
    end

    // Mode register write at the last data bit of a matching write frame
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            global_mode_control <= `GMC_RESET;
        end else if (frame_step && write_hit) begin
            global_mode_control <= {data_shift[14:0], mdio_in} & `GMC_WRITE_MASK;
        end
    end

    // Effective mode levels towards the datapath
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            gig_eth_idle_handling <= 1'b0;
            busy_sequence_passthrough <= 1'b0;
            clock_tolerance_comp_on <= 1'b1;
            pattern_check_global_on <= 1'b0;
            pattern_gen_global_on <= 1'b0;
            global_tx_emphasis_level <= 2'h3;
        end else if (clk_en) begin
            gig_eth_idle_handling <= ge_eff;
            busy_sequence_passthrough <= ge_eff & busy_eff;
            clock_tolerance_comp_on <= global_mode_control[`GMC_CTC_BIT];
            pattern_check_global_on <= global_mode_control[`GMC_CHECK_BIT];
            pattern_gen_global_on <= global_mode_control[`GMC_GEN_BIT];
            global_tx_emphasis_level <= global_mode_control[`GMC_EMPH_HI:`GMC_EMPH_LO];
        end
    end

    // Receive idle classification of the character following a comma
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rx_prev_comma <= 1'b0;
            rx_idle_seq <= 1'b0;
            rx_busy_data <= 1'b0;
        end else if (clk_en) begin
            rx_idle_seq <= 1'b0;
            rx_busy_data <= 1'b0;
            if (rx_code_valid) begin
                rx_prev_comma <= is_comma(rx_is_control, rx_code);
                if (rx_prev_comma && !rx_is_control && ge_eff) begin
                    if (rx_code == `CODE_D10_1 && busy_eff) begin
                        rx_busy_data <= 1'b1;
                    end else begin
                        rx_idle_seq <= 1'b1;
                    end
                end
            end
        end
    end

    // Transmit disparity correction of the idle pair
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            tx_prev_comma <= 1'b0;
            tx_code_out_valid <= 1'b0;
            tx_code_out <= 8'h00;
            tx_is_control_out <= 1'b0;
        end else if (clk_en) begin
            tx_code_out_valid <= tx_code_valid;
            tx_is_control_out <= tx_is_control;
            tx_code_out <= tx_code;
            if (tx_code_valid) begin
                tx_prev_comma <= is_comma(tx_is_control, tx_code);
                if (ge_eff && tx_prev_comma && !tx_is_control && tx_code == `CODE_D15_2) begin
                    tx_code_out <= `CODE_D5_6;
                end
            end
        end
    end

endmodule

`default_nettype wire

// File: verification/serdes_ctrl_sva.sv
// Port-level checker for the global control register bank
`timescale 1ns/100ps
`default_nettype none
`include "serdes_ctrl_params.svh"
module serdes_ctrl_sva (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic gig_eth_select_pin,
    input wire logic busy_passthrough_pin,
    input wire logic rx_code_valid,
    input wire logic [7:0] rx_code,
    input wire logic rx_is_control,
    input wire logic rx_idle_seq,
    input wire logic rx_busy_data,
    input wire logic tx_code_valid,
    input wire logic [7:0] tx_code,
    input wire logic tx_is_control,
    input wire logic [7:0] tx_code_out,
    input wire logic mdio_out,
    input wire logic mdio_oe_n,
    input wire logic gig_eth_idle_handling,
    input wire logic busy_sequence_passthrough,
    input wire logic [1:0] global_tx_emphasis_level
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    AST_IDLE_AFTER_DATA: assert property (rx_idle_seq |-> $past(clk_en && rx_code_valid && !rx_is_control))
        else $error("idle pulse without a data character");
    AST_BUSY_ON_D10_1: assert property (rx_busy_data |-> $past(rx_code) == `CODE_D10_1)
        else $error("busy pulse on a wrong character");
    AST_BUSY_GATED: assert property (busy_sequence_passthrough |-> gig_eth_idle_handling)
        else $error("busy mode shown outside gig-eth mode");
    AST_GIG_PIN_OR: assert property (clk_en && gig_eth_select_pin |=> gig_eth_idle_handling)
        else $error("gig-eth pin not reflected");
    AST_BUSY_PIN_OR: assert property (clk_en && gig_eth_select_pin && busy_passthrough_pin |=> busy_sequence_passthrough)
        else $error("busy pin not reflected");
    AST_D15_2_SWAP: assert property (clk_en && tx_code_valid && !tx_is_control && tx_code == `CODE_D15_2
        && gig_eth_select_pin && $past(clk_en && tx_code_valid && tx_is_control && tx_code == `CODE_K28_5)
        |=> tx_code_out == `CODE_D5_6)
        else $error("disparity substitution missing");
    AST_TX_COPY: assert property (clk_en && tx_code_valid && tx_code != `CODE_D15_2 |=> tx_code_out == $past(tx_code))
        else $error("transmit character altered");
    AST_EMPH_RESET: assert property ($rose(rst_n) |-> global_tx_emphasis_level == 2'h3)
        else $error("emphasis reset value wrong");
    AST_TURNAROUND_ZERO: assert property ($fell(mdio_oe_n) |-> !mdio_out)
        else $error("turnaround bit not zero");
endmodule
bind global_serdes_control_regs serdes_ctrl_sva chk (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
    .gig_eth_select_pin(gig_eth_select_pin), .busy_passthrough_pin(busy_passthrough_pin),
    .rx_code_valid(rx_code_valid), .rx_code(rx_code), .rx_is_control(rx_is_control), .rx_idle_seq(rx_idle_seq),
    .rx_busy_data(rx_busy_data), .tx_code_valid(tx_code_valid), .tx_code(tx_code), .tx_is_control(tx_is_control),
    .tx_code_out(tx_code_out), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n),
    .gig_eth_idle_handling(gig_eth_idle_handling), .busy_sequence_passthrough(busy_sequence_passthrough),
    .global_tx_emphasis_level(global_tx_emphasis_level));
`default_nettype wire

// File: verification/mdio_station.sv
// Management station model sending clause 22 frames
`timescale 1ns/100ps
`default_nettype none
module mdio_station (
    input wire logic sys_clk,
    input wire logic mdio_wire,
    output logic mdc,
    output logic st_data,
    output logic st_drive
);
    initial begin
        mdc = 1'b0;
        st_data = 1'b1;
        st_drive = 1'b0;
    end
    // Data changes while mdc is low; the wire is sampled at the mdc rise; released from turnaround on reads
    task automatic xfer(input logic wr, input logic [4:0] pa, input logic [4:0] ra,
                        input logic [15:0] wd, output logic [15:0] rd);
        logic [63:0] f;
        f = {32'hffff_ffff, 2'b01, wr ? 2'b01 : 2'b10, pa, ra, 2'b10, wd};
        rd = 16'h0;
        for (int i = 63; i >= 0; i--) begin
            @(posedge sys_clk);
            st_data <= f[i];
            st_drive <= wr || i > 17;
            mdc <= 1'b0;
            repeat (4) @(posedge sys_clk);
            mdc <= 1'b1;
            if (i < 16) rd[i] = mdio_wire;
            repeat (3) @(posedge sys_clk);
        end
        @(posedge sys_clk);
        st_drive <= 1'b0;
        mdc <= 1'b0;
    endtask
endmodule
`default_nettype wire

// File: verification/tb_global_serdes_control_regs.sv
// Self-checking bench for the global control register bank
`timescale 1ns/100ps
`default_nettype none
`include "serdes_ctrl_params.svh"
module tb_global_serdes_control_regs;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic gig_eth_select_pin = 1'b0, busy_passthrough_pin = 1'b0;
    logic rx_code_valid = 1'b0, rx_is_control = 1'b0, tx_code_valid = 1'b0, tx_is_control = 1'b0;
    logic [7:0] rx_code = 8'h0, tx_code = 8'h0, tx_code_out;
    logic mdc, st_data, st_drive, mdio_out, mdio_oe_n, rx_idle_seq, rx_busy_data;
    logic gig, busy, ctc, chk_on, gen_on, tx_ov, tx_co;
    logic clk_en = 1'b1;
    logic [1:0] emph;
    wire logic mdio_wire;
    int fail_count = 0;
    int compares = 0;
    localparam logic [4:0] PHY = 5'h05;
    // Pull-up on the shared data line
    assign mdio_wire = !mdio_oe_n ? mdio_out : (st_drive ? st_data : 1'b1);
    always #25 sys_clk = ~sys_clk;
    global_serdes_control_regs uut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .phy_address(PHY),
        .mdc(mdc), .mdio_in(mdio_wire), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n),
        .gig_eth_select_pin(gig_eth_select_pin), .busy_passthrough_pin(busy_passthrough_pin),
        .rx_code_valid(rx_code_valid), .rx_code(rx_code), .rx_is_control(rx_is_control),
        .rx_idle_seq(rx_idle_seq), .rx_busy_data(rx_busy_data), .tx_code_valid(tx_code_valid),
        .tx_code(tx_code), .tx_is_control(tx_is_control), .tx_code_out_valid(tx_ov), .tx_code_out(tx_code_out),
        .tx_is_control_out(tx_co), .gig_eth_idle_handling(gig), .busy_sequence_passthrough(busy),
        .clock_tolerance_comp_on(ctc), .pattern_check_global_on(chk_on), .pattern_gen_global_on(gen_on),
        .global_tx_emphasis_level(emph));
    mdio_station st (.sys_clk(sys_clk), .mdio_wire(mdio_wire), .mdc(mdc), .st_data(st_data), .st_drive(st_drive));
    task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic conclude;
        if (fail_count == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic wr(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] d);
        logic [15:0] unused;
        st.xfer(1'b1, pa, ra, d, unused);
        repeat (3) @(posedge sys_clk);
    endtask
    task automatic rdchk(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] exp);
        logic [15:0] v;
        st.xfer(1'b0, pa, ra, 16'h0, v);
        cmp("read data", exp, v);
    endtask
    // Order: gig-eth, busy, clock comp, check, generate, emphasis
    task automatic mode_chk(input logic [6:0] e);
        repeat (3) @(posedge sys_clk);
        cmp("mode outputs", {9'h0, e}, {9'h0, gig, busy, ctc, chk_on, gen_on, emph});
    endtask
    task automatic pins(input logic g, input logic b);
        @(posedge sys_clk);
        gig_eth_select_pin <= g;
        busy_passthrough_pin <= b;
        repeat (3) @(posedge sys_clk);
    endtask
    // Expected: idle pulse, busy pulse, transmitted second character
    task automatic pair(input logic [7:0] c2, input logic [9:0] e);
        @(posedge sys_clk);
        {rx_code_valid, rx_is_control, rx_code} <= {2'b11, `CODE_K28_5};
        {tx_code_valid, tx_is_control, tx_code} <= {2'b11, `CODE_K28_5};
        @(posedge sys_clk);
        {rx_is_control, rx_code, tx_is_control, tx_code} <= {1'b0, c2, 1'b0, c2};
        @(posedge sys_clk);
        rx_code_valid <= 1'b0;
        tx_code_valid <= 1'b0;
        #1;
        cmp("pair result", {4'h0, 2'b10, e}, {4'h0, tx_ov, tx_co, rx_idle_seq, rx_busy_data, tx_code_out});
    endtask
    task automatic t_reset;
        mode_chk(7'b0010011);
        rdchk(PHY, `REG_GLOBAL_MODE_CONTROL, `GMC_RESET);
    endtask
    task automatic t_mask;
        wr(PHY, `REG_GLOBAL_MODE_CONTROL, 16'hffff);
        rdchk(PHY, `REG_GLOBAL_MODE_CONTROL, 16'hd30c);
        mode_chk(7'b1111111);
        wr(PHY, `REG_GLOBAL_MODE_CONTROL, 16'h4000);
        mode_chk(7'b0000000);
    endtask
    task automatic t_emph;
        for (int e = 0; e < 4; e++) begin
            wr(PHY, `REG_GLOBAL_MODE_CONTROL, {12'h0, e[1:0], 2'b00});
            mode_chk({5'h0, e[1:0]});
        end
    endtask
    task automatic t_reserved;
        logic [4:0] ra [5] = '{5'h17, 5'h19, 5'h1a, 5'h1b, 5'h1c};
        foreach (ra[i]) begin
            wr(PHY, ra[i], 16'hffff);
            rdchk(PHY, ra[i], 16'h0000);
        end
        wr(5'h06, `REG_GLOBAL_MODE_CONTROL, 16'hffff);
        rdchk(PHY, `REG_GLOBAL_MODE_CONTROL, 16'h000c);
        rdchk(5'h06, `REG_GLOBAL_MODE_CONTROL, 16'hffff);
    endtask
    task automatic t_freeze;
        @(posedge sys_clk);
        clk_en <= 1'b0;
        pins(1'b1, 1'b0);
        cmp("frozen mode", 16'h0000, {15'h0, gig});
        @(posedge sys_clk);
        clk_en <= 1'b1;
        repeat (3) @(posedge sys_clk);
        cmp("released mode", 16'h0001, {15'h0, gig});
        pins(1'b0, 1'b0);
    endtask
    task automatic t_rxtx;
        pins(1'b1, 1'b0);
        pair(8'h50, {2'b10, 8'h50});
        pair(`CODE_D10_1, {2'b10, `CODE_D10_1});
        pair(`CODE_D15_2, {2'b10, `CODE_D5_6});
        pins(1'b1, 1'b1);
        pair(`CODE_D10_1, {2'b01, `CODE_D10_1});
        pins(1'b0, 1'b1);
        pair(`CODE_D10_1, {2'b00, `CODE_D10_1});
        pair(`CODE_D15_2, {2'b00, `CODE_D15_2});
        pins(1'b0, 1'b0);
        wr(PHY, `REG_GLOBAL_MODE_CONTROL, 16'h8000);
        pair(8'h50, {2'b10, 8'h50});
    endtask
    initial begin
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_reset();
        t_mask();
        t_emph();
        t_reserved();
        t_freeze();
        t_rxtx();
        conclude();
    end
    initial begin
        #3000000;
        fail_count++;
        conclude();
    end
endmodule
`default_nettype wire
